// ### inc/serial_link_regs.vh
// register offsets, field positions, reset values and counts for the
// serial link tuning block; definitions only, included by bare name.
`ifndef SERIAL_LINK_REGS_VH
`define SERIAL_LINK_REGS_VH
`define DEV_SER          1'b0
`define DEV_DES          1'b1
`define OFS_SETUP        8'h05
`define OFS_INT_STATE    8'h06
`define OFS_SPREAD       8'h07
`define OFS_FORCE_INT    8'h0e
`define FLD_INT_STATE    4
`define FLD_FORCE_INT    0
`define RST_DRV_SETUP    6'h30
`define RST_EQ_BOOST     4'h4
`define EQ_DFLT_HIGH     4'h4
`define EQ_DFLT_LOW      4'h9
`define EQ_MAX           4'hb
`define SER_SS_DFLT_HIGH 3'h1
`define SER_SS_DFLT_LOW  3'h0
`define DES_SS_DFLT_HIGH 2'h1
`define DES_SS_DFLT_LOW  2'h0
`define RELAY_DELAY      8'h04
`endif

// ### rtl/int_relay.v
// carries the remote interrupt level over the reverse control channel.
// assumes level_i and chan_up_i are already on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
module int_relay #(
  parameter [7:0] DELAY = 8'h04
) (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       reset_i,
  // level to carry and channel state
  input  wire       level_i,
  input  wire       chan_up_i,
  // delivered level and pending flag
  output reg        sent_o,
  output reg        pend_o
);

reg  [7:0] cnt;

////////////////////////////////////////////////////////////////////////
// a pending change waits for the channel, then spends DELAY+1 cycles in
// flight; an outage restarts the flight so nothing is half delivered
always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    sent_o <= 1'b0;
    pend_o <= 1'b0;
    cnt    <= 8'h00;
  end
  else if (level_i == sent_o)
  begin
    pend_o <= 1'b0;
    cnt    <= 8'h00;
  end
  else if (!chan_up_i)
  begin
    pend_o <= 1'b1;
    cnt    <= 8'h00;
  end
  else if (cnt == DELAY)
  begin
    sent_o <= level_i;
    pend_o <= 1'b0;
    cnt    <= 8'h00;
  end
  else
  begin
    pend_o <= 1'b1;
    cnt    <= cnt + 8'h01;
  end
end

endmodule
`default_nettype wire

// ### rtl/serial_link_tuning_and_spread_ctrl.v
// register bank and side-band logic of the serializer/deserializer pair.
// assumes the control channel has already decoded host packets into
// single-cycle register reads and writes on sys_clk_i; pins are async.
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_regs.vh"
module serial_link_tuning_and_spread_ctrl #(
  parameter [7:0] RELAY_DELAY = `RELAY_DELAY
) (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       reset_i,
  // decoded register access from the control channel
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire       reg_dev_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_ack_o,
  // device pins, asynchronous
  input  wire       remote_int_i,
  input  wire       reverse_chan_up_i,
  input  wire       power_down_n_i,
  input  wire       equalizer_default_pin_i,
  input  wire       ser_spread_default_pin_i,
  input  wire       des_spread_default_pin_i,
  // interrupt out of the serializer
  output reg        int_o,
  output reg        int_pending_o,
  // analog and modulator controls
  output reg  [3:0] preemph_o,
  output reg  [1:0] drive_level_field_o,
  output reg  [3:0] eq_boost_o,
  output reg  [2:0] ser_spread_o,
  output reg        ser_link_spread_o,
  output reg  [1:0] des_spread_o,
  output reg        des_par_spread_o
);

////////////////////////////////////////////////////////////////////////
// decoding helpers

// preemphasis codes 0101..0111 are not settings; fall back to none
function [3:0] preemph_valid;
  input [3:0] code;
  begin
    if (code[3] || code[2:0] <= 3'h4)
      preemph_valid = code;
    else
      preemph_valid = 4'h0;
  end
endfunction

// true when a spread code selects any modulation
function spread_on;
  input [2:0] code;
  input       ser;
  begin
    if (ser)
      spread_on = (code[1:0] != 2'b00);
    else
      spread_on = code[0];
  end
endfunction

// one register of one device hit by the current write strobe; every
// write enable goes through this so the decodes cannot drift apart
function wr_hit;
  input       wr;
  input       dev_is;
  input       dev_want;
  input [7:0] addr_is;
  input [7:0] addr_want;
  begin
    wr_hit = wr && (dev_is == dev_want) && (addr_is == addr_want);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers, two flops each before any use; each pin has its
// own pair so that only the second flop is ever read
wire [5:0] pin_raw;
wire [5:0] pin_sync;
genvar     gi;

assign pin_raw = {remote_int_i, reverse_chan_up_i, power_down_n_i,
                  equalizer_default_pin_i, ser_spread_default_pin_i,
                  des_spread_default_pin_i};

generate
  for (gi = 0; gi < 6; gi = gi + 1)
  begin : g_sync
    reg  meta;
    reg  sync;
    always @(posedge sys_clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        meta <= 1'b0;
        sync <= 1'b0;
      end
      else
      begin
        meta <= pin_raw[gi];
        sync <= meta;
      end
    end
    assign pin_sync[gi] = sync;
  end
endgenerate

wire rint_s  = pin_sync[5];
wire chan_s  = pin_sync[4];
wire pwdn_n_s = pin_sync[3];
wire eqdef_s = pin_sync[2];
wire ssdef_s = pin_sync[1];
wire dsdef_s = pin_sync[0];

////////////////////////////////////////////////////////////////////////
// default loading at power-up and on power-down resume; the boot
// shifter waits until the synchronised pins carry real levels
reg  [2:0] boot;
reg        pwdn_q;
reg        load_dflt;

always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    boot      <= 3'b000;
    pwdn_q    <= 1'b0;
    load_dflt <= 1'b0;
  end
  else
  begin
    boot      <= {boot[1:0], 1'b1};
    pwdn_q    <= pwdn_n_s;
    load_dflt <= (boot == 3'b011) || (pwdn_n_s && !pwdn_q);
  end
end

////////////////////////////////////////////////////////////////////////
// register storage
reg  [5:0] drv_setup;
reg  [3:0] eq_boost;
reg  [2:0] ser_ss;
reg  [1:0] des_ss;
reg        force_int;

wire wr_drv_setup = wr_hit(reg_wr_i, reg_dev_i, `DEV_SER, reg_addr_i, `OFS_SETUP);
wire wr_force_int = wr_hit(reg_wr_i, reg_dev_i, `DEV_SER, reg_addr_i, `OFS_FORCE_INT);
wire wr_ser_ss    = wr_hit(reg_wr_i, reg_dev_i, `DEV_SER, reg_addr_i, `OFS_SPREAD);
wire wr_eq_boost  = wr_hit(reg_wr_i, reg_dev_i, `DEV_DES, reg_addr_i, `OFS_SETUP);
wire wr_des_ss    = wr_hit(reg_wr_i, reg_dev_i, `DEV_DES, reg_addr_i, `OFS_SPREAD);

// host writes; a default load at the same edge takes precedence since
// the pins describe the state the device just woke into
always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    drv_setup <= `RST_DRV_SETUP;
    eq_boost  <= `RST_EQ_BOOST;
    ser_ss    <= `SER_SS_DFLT_LOW;
    des_ss    <= `DES_SS_DFLT_LOW;
    force_int <= 1'b0;
  end
  else
  begin
    if (wr_drv_setup)
      drv_setup <= reg_wdata_i[5:0];
    if (wr_force_int)
      force_int <= reg_wdata_i[`FLD_FORCE_INT];
    if (load_dflt)
    begin
      eq_boost <= eqdef_s ? `EQ_DFLT_HIGH : `EQ_DFLT_LOW;
      ser_ss   <= ssdef_s ? `SER_SS_DFLT_HIGH : `SER_SS_DFLT_LOW;
      des_ss   <= dsdef_s ? `DES_SS_DFLT_HIGH : `DES_SS_DFLT_LOW;
    end
    else
    begin
      if (wr_eq_boost)
        eq_boost <= reg_wdata_i[3:0];
      if (wr_ser_ss)
        ser_ss <= reg_wdata_i[2:0];
      if (wr_des_ss)
        des_ss <= reg_wdata_i[1:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// interrupt carried over the reverse channel
wire int_sent;
wire int_pend;

int_relay #(
  .DELAY     (RELAY_DELAY)
) u_relay (
  .sys_clk_i (sys_clk_i),
  .reset_i   (reset_i),
  .level_i   (rint_s),
  .chan_up_i (chan_s),
  .sent_o    (int_sent),
  .pend_o    (int_pend)
);

// forced interrupt ors onto the carried level, independent of remote
always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    int_o         <= 1'b0;
    int_pending_o <= 1'b0;
  end
  else
  begin
    int_o         <= int_sent | force_int;
    int_pending_o <= int_pend;
  end
end

////////////////////////////////////////////////////////////////////////
// read data, one cycle after the strobe; unmapped reads return zero
// the interrupt state bit shows the synchronised pin, not the relayed
// level, so the host sees the pin even while the channel is down
reg  [7:0] next_rdata;

always @*
begin
  next_rdata = 8'h00;
  if (reg_dev_i == `DEV_SER)
  begin
    case (reg_addr_i)
      `OFS_SETUP:     next_rdata = {2'b00, drv_setup};
      `OFS_SPREAD:    next_rdata = {5'h00, ser_ss};
      `OFS_FORCE_INT: next_rdata = {7'h00, force_int};
      default:        next_rdata = 8'h00;
    endcase
  end
  else
  begin
    case (reg_addr_i)
      `OFS_SETUP:     next_rdata = {4'h0, eq_boost};
      `OFS_INT_STATE: next_rdata[`FLD_INT_STATE] = rint_s;
      `OFS_SPREAD:    next_rdata = {6'h00, des_ss};
      default:        next_rdata = 8'h00;
    endcase
  end
end

always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    reg_rdata_o <= 8'h00;
    reg_ack_o   <= 1'b0;
  end
  else
  begin
    reg_ack_o <= reg_wr_i | reg_rd_i;
    if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end
end

////////////////////////////////////////////////////////////////////////
// analog and modulator controls, registered decodes
always @(posedge sys_clk_i or posedge reset_i)
begin
  if (reset_i)
  begin
    preemph_o           <= 4'h0;
    drive_level_field_o <= 2'b11;
    eq_boost_o          <= `RST_EQ_BOOST;
    ser_spread_o        <= 3'h0;
    ser_link_spread_o   <= 1'b0;
    des_spread_o        <= 2'h0;
    des_par_spread_o    <= 1'b0;
  end
  else
  begin
    preemph_o <= preemph_valid(drv_setup[3:0]);
    // code 00 has no strength of its own; keep full drive
    if (drv_setup[5:4] == 2'b00)
      drive_level_field_o <= 2'b11;
    else
      drive_level_field_o <= drv_setup[5:4];
    // boost beyond the top level clamps rather than wrapping low
    if (eq_boost > `EQ_MAX)
      eq_boost_o <= `EQ_MAX;
    else
      eq_boost_o <= eq_boost;
    ser_spread_o      <= ser_ss;
    ser_link_spread_o <= spread_on(ser_ss, 1'b1);
    des_spread_o      <= des_ss;
    des_par_spread_o  <= spread_on({1'b0, des_ss}, 1'b0);
  end
end

endmodule
`default_nettype wire

// ### verif/link_ctrl_sva.sv
// checker for the serial link tuning block, ports only.
// assumes the block's own ports; attached by bind below.
`timescale 1ns/10ps
`default_nettype none
module link_ctrl_sva (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  // register access
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_ack_o,
  // controls
  input wire logic [3:0] preemph_o,
  input wire logic [1:0] drive_level_field_o,
  input wire logic [3:0] eq_boost_o,
  input wire logic [2:0] ser_spread_o,
  input wire logic       ser_link_spread_o,
  input wire logic [1:0] des_spread_o,
  input wire logic       des_par_spread_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // any strobe, read or write
  sequence s_strobe;
    reg_wr_i || reg_rd_i;
  endsequence
  chk_ack_after_strobe: assert property (s_strobe |=> reg_ack_o)
    else $error("ack missing after strobe");
  chk_ack_no_strobe: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
    else $error("ack without strobe");
  chk_rdata_on_read: assert property ($changed(reg_rdata_o) |-> $past(reg_rd_i))
    else $error("read data moved without read");
  chk_preemph_valid: assert property (!(preemph_o inside {[4'h5:4'h7]}))
    else $error("invalid preemphasis code");
  chk_drive_level: assert property (drive_level_field_o != 2'h0)
    else $error("drive level zero");
  chk_eq_range: assert property (eq_boost_o <= 4'hb)
    else $error("boost above top code");
  chk_ser_spread_on: assert property (ser_link_spread_o == (ser_spread_o[1:0] != 2'h0))
    else $error("serializer spread enable wrong");
  chk_des_spread_on: assert property (des_par_spread_o == des_spread_o[0])
    else $error("deserializer spread enable wrong");
endmodule
bind serial_link_tuning_and_spread_ctrl link_ctrl_sva u_sva (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .preemph_o(preemph_o),
  .drive_level_field_o(drive_level_field_o), .eq_boost_o(eq_boost_o),
  .ser_spread_o(ser_spread_o), .ser_link_spread_o(ser_link_spread_o),
  .des_spread_o(des_spread_o), .des_par_spread_o(des_par_spread_o));
`default_nettype wire

// ### verif/remote_end_model.sv
// remote deserializer interrupt pin and reverse channel state.
// assumes the bench calls drive() from its own thread.
`timescale 1ns/10ps
`default_nettype none
module remote_end_model (
  input  wire logic sys_clk_i,
  output var logic  int_pin_o,
  output var logic  chan_up_o
);
  initial
  begin
    int_pin_o = 1'b0;
    chan_up_o = 1'b1;
  end
  // changes land just after an edge, never mid-cycle
  task automatic drive(input logic lvl, input logic up);
    @(posedge sys_clk_i);
    int_pin_o <= lvl;
    chan_up_o <= up;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the serial link tuning block.
// assumes decoded single-cycle register strobes, ack one cycle later.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       sys_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, reg_dev_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, v;
  logic       reg_ack_o, int_o, int_pending_o, rint, rchan, eqp = 1, sp_s = 1, sp_d = 0;
  logic       pd_n = 1, ser_link_spread_o, des_par_spread_o;
  logic [3:0] preemph_o, eq_boost_o;
  logic [2:0] ser_spread_o;
  logic [1:0] drive_level_field_o, des_spread_o;
  int         n_mismatch = 0, samples_checked = 0, i;
  always #5 sys_clk_i = ~sys_clk_i;
  remote_end_model remote (.sys_clk_i(sys_clk_i), .int_pin_o(rint), .chan_up_o(rchan));
  serial_link_tuning_and_spread_ctrl dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_dev_i(reg_dev_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .remote_int_i(rint),
    .reverse_chan_up_i(rchan), .power_down_n_i(pd_n), .equalizer_default_pin_i(eqp),
    .ser_spread_default_pin_i(sp_s), .des_spread_default_pin_i(sp_d), .int_o(int_o),
    .int_pending_o(int_pending_o), .preemph_o(preemph_o),
    .drive_level_field_o(drive_level_field_o), .eq_boost_o(eq_boost_o),
    .ser_spread_o(ser_spread_o), .ser_link_spread_o(ser_link_spread_o),
    .des_spread_o(des_spread_o), .des_par_spread_o(des_par_spread_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one access; strobe drops after the taking edge, ack seen next cycle
  task automatic acc(input logic w, input logic d, input logic [7:0] a, input logic [7:0] wd);
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i, reg_dev_i, reg_addr_i, reg_wdata_i} <= {w, !w, d, a, wd};
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    #1 chk("ack", {7'h0, reg_ack_o}, 8'h01);
    v = reg_rdata_o;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd(input logic d, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, d, a, 8'h00);
    chk("rdata", v, e);
  endtask
  // bounded wait on the interrupt output
  task automatic wait_int(input logic e);
    for (int k = 0; k < 40 && int_o !== e; k++)
      @(posedge sys_clk_i) #1;
    chk("int_o", {7'h0, int_o}, {7'h0, e});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 0;
    repeat (8) @(posedge sys_clk_i);
    rd(0, 8'h05, 8'h30);
    rd(1, 8'h05, 8'h04);
    rd(0, 8'h07, 8'h01);
    rd(1, 8'h07, 8'h00);
    $display("defaults done");
    // straps move without a resume: nothing reloads
    @(posedge sys_clk_i) {eqp, sp_s, sp_d} <= 3'b001;
    repeat (10) @(posedge sys_clk_i);
    rd(1, 8'h05, 8'h04);
    @(posedge sys_clk_i) pd_n <= 0;
    repeat (4) @(posedge sys_clk_i);
    pd_n <= 1;
    repeat (12) @(posedge sys_clk_i);
    rd(1, 8'h05, 8'h09);
    rd(0, 8'h07, 8'h00);
    rd(1, 8'h07, 8'h01);
    chk("des_par", {7'h0, des_par_spread_o}, 8'h01);
    $display("resume done");
    // host keeps only one side spreading
    acc(1, 1, 8'h07, 8'h00);
    for (i = 0; i < 64; i++)
    begin
      acc(1, 0, 8'h05, i[7:0]);
      chk("preemph", {4'h0, preemph_o}, (i[3:0] inside {[5:7]}) ? 8'h00 : {4'h0, i[3:0]});
      chk("drive", {6'h0, drive_level_field_o}, i[5:4] == 0 ? 8'h03 : {6'h0, i[5:4]});
      if (i < 16)
      begin
        acc(1, 1, 8'h05, i[7:0]);
        chk("eq", {4'h0, eq_boost_o}, i > 11 ? 8'h0b : i[7:0]);
      end
      if (i < 8)
      begin
        // bench parallel clock is taken as slow, so every rate is legal
        acc(1, 0, 8'h07, i[7:0]);
        chk("ser_ss", {5'h0, ser_spread_o}, i[7:0]);
        chk("ser_link", {7'h0, ser_link_spread_o}, {7'h0, i[1:0] != 0});
      end
    end
    rd(0, 8'h05, 8'h3f);
    rd(1, 8'h05, 8'h0f);
    acc(1, 0, 8'h07, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      acc(1, 1, 8'h07, i[7:0]);
      chk("des_ss", {6'h0, des_spread_o}, i[7:0]);
      chk("des_par", {7'h0, des_par_spread_o}, {7'h0, i[0]});
    end
    rd(0, 8'h3f, 8'h00);
    $display("fields done");
    remote.drive(1, 1);
    wait_int(1);
    rd(1, 8'h06, 8'h10);
    remote.drive(1, 0);
    repeat (5) @(posedge sys_clk_i);
    remote.drive(0, 0);
    repeat (30) @(posedge sys_clk_i);
    #1 chk("held", {6'h0, int_o, int_pending_o}, 8'h03);
    remote.drive(0, 1);
    wait_int(0);
    rd(1, 8'h06, 8'h00);
    acc(1, 0, 8'h0e, 8'h01);
    rd(0, 8'h0e, 8'h01);
    wait_int(1);
    acc(1, 0, 8'h0e, 8'h00);
    wait_int(0);
    $display("interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
